//--- sram_pkg.sv
// constants and types shared by the burst sram core and its scan port
`default_nettype none
package sram_pkg;
    localparam int          LANE_W      = 9;     // data bits per byte lane, parity bit included
    localparam int          DEF_LANES   = 4;     // wide variant: 4 lanes of 9 bits
    localparam int          DEF_ADDR_W  = 18;    // wide variant: 256K words
    localparam int          BURST_W     = 2;     // burst counter covers four beats
    localparam int          MAX_CLK_MHZ = 250;   // fastest rated grade, zero wait states
    localparam int          REF_CLK_MHZ = 100;   // clock this model runs at
    localparam int          IR_W        = 3;
    localparam int          IDCODE_W    = 32;
    localparam logic [31:0] IDCODE_DEF  = 32'h0ABC_0001; // arbitrary neutral value
    localparam logic [2:0]  IR_EXTEST   = 3'h0;
    localparam logic [2:0]  IR_IDCODE   = 3'h1;
    localparam logic [2:0]  IR_SAMPLE   = 3'h2;
    localparam logic [2:0]  IR_BYPASS   = 3'h7;
    localparam logic [1:0]  CAPT_IR     = 2'h1;  // pattern loaded into the ir shift register (irsh_r) on capture

    typedef enum logic [1:0] {
        OP_IDLE  = 2'h0,
        OP_READ  = 2'h1,
        OP_WRITE = 2'h3
    } op_e;

    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
        TAP_SH_DR  = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR  = 4'h5, TAP_EX2_DR = 4'h4,
        TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR  = 4'hE,
        TAP_EX1_IR = 4'hA, TAP_PA_IR  = 4'hB, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
    } tap_state_e;
endpackage : sram_pkg
`default_nettype wire

//--- scan_if.sv
// scan port signals passed from the sram top to its test access port
`timescale 1ns/10ps
`default_nettype none
interface scan_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport top (output tck, output tms, output tdi, input tdo, input tdo_oe);
    modport tap (input tck, input tms, input tdi, output tdo, output tdo_oe);
endinterface : scan_if
`default_nettype wire

//--- sram_scan_tap.sv
// boundary-scan test access port: state machine, instruction, bypass and id registers
`timescale 1ns/10ps
`default_nettype none
module sram_scan_tap
    import sram_pkg::*;
#(
    parameter logic [IDCODE_W-1:0] ID_VALUE = IDCODE_DEF // arbitrary value
) (
    input  wire logic i_ref_clk, // system clock
    input  wire logic i_rst,     // async reset, active high
    scan_if.tap       scan       // scan pins
);
    tap_state_e            st_r,    st_nxt;
    logic [IR_W-1:0]       ir_r,    ir_nxt;
    logic [IR_W-1:0]       irsh_r,  irsh_nxt;
    logic [IDCODE_W-1:0]   dr_r,    dr_nxt;
    logic                  tdo_r,   tdo_nxt;
    logic                  oe_r,    oe_nxt;
    logic                  tck_q_r;
    logic                  rise;
    logic                  fall;
    logic                  is_id;

    // tck is a slow pin sampled on the system clock
    assign rise   = scan.tck & ~tck_q_r;
    assign fall   = ~scan.tck & tck_q_r;
    assign is_id  = (ir_r == IR_IDCODE);
    assign scan.tdo    = tdo_r;
    assign scan.tdo_oe = oe_r;

    always_comb begin
        st_nxt   = st_r;
        ir_nxt   = ir_r;
        irsh_nxt = irsh_r;
        dr_nxt   = dr_r;
        tdo_nxt  = tdo_r;
        oe_nxt   = oe_r;
        if (rise) begin
            case (st_r)
                TAP_RESET:  st_nxt = scan.tms ? TAP_RESET  : TAP_IDLE;
                TAP_IDLE:   st_nxt = scan.tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: st_nxt = scan.tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: st_nxt = scan.tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  st_nxt = scan.tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: st_nxt = scan.tms ? TAP_UPD_DR : TAP_PA_DR;
                TAP_PA_DR:  st_nxt = scan.tms ? TAP_EX2_DR : TAP_PA_DR;
                TAP_EX2_DR: st_nxt = scan.tms ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: st_nxt = scan.tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: st_nxt = scan.tms ? TAP_RESET  : TAP_CAP_IR;
                TAP_CAP_IR: st_nxt = scan.tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  st_nxt = scan.tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: st_nxt = scan.tms ? TAP_UPD_IR : TAP_PA_IR;
                TAP_PA_IR:  st_nxt = scan.tms ? TAP_EX2_IR : TAP_PA_IR;
                TAP_EX2_IR: st_nxt = scan.tms ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: st_nxt = scan.tms ? TAP_SEL_DR : TAP_IDLE;
                default:    st_nxt = TAP_RESET;
            endcase
            case (st_r)
                TAP_RESET:  ir_nxt = IR_IDCODE;
                TAP_CAP_IR: irsh_nxt = {{(IR_W-2){1'b0}}, CAPT_IR};
                TAP_SH_IR:  irsh_nxt = {scan.tdi, irsh_r[IR_W-1:1]};
                TAP_UPD_IR: ir_nxt = irsh_r;
                TAP_CAP_DR: dr_nxt = is_id ? ID_VALUE : '0;
                // boundary cells are not modelled: every other instruction scans as bypass
                TAP_SH_DR:  dr_nxt = is_id ? {scan.tdi, dr_r[IDCODE_W-1:1]} : {{(IDCODE_W-1){1'b0}}, scan.tdi};
                default:    ir_nxt = ir_r;
            endcase
        end
        // tdo changes on the falling edge, as scan chains expect
        if (fall) begin
            oe_nxt  = (st_r == TAP_SH_DR) || (st_r == TAP_SH_IR);
            tdo_nxt = (st_r == TAP_SH_IR) ? irsh_r[0] : dr_r[0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r    <= TAP_RESET;
            ir_r    <= IR_IDCODE;
            irsh_r  <= '0;
            dr_r    <= '0;
            tdo_r   <= 1'b0;
            oe_r    <= 1'b0;
            tck_q_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ir_r    <= ir_nxt;
            irsh_r  <= irsh_nxt;
            dr_r    <= dr_nxt;
            tdo_r   <= tdo_nxt;
            oe_r    <= oe_nxt;
            tck_q_r <= scan.tck;
        end
    end
endmodule : sram_scan_tap
`default_nettype wire

//--- sync_burst_sram.sv
// pipelined synchronous burst sram with registered inputs and outputs
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram
    import sram_pkg::*;
#(
    parameter int                  LANES    = DEF_LANES,   // 4 for x36, 2 for x18
    parameter int                  ADDR_W   = DEF_ADDR_W,  // 18 for x36, 19 for x18
    parameter logic [IDCODE_W-1:0] ID_VALUE = IDCODE_DEF   // arbitrary value
) (
    input  wire logic                    i_ref_clk,             // clock
    input  wire logic                    i_rst,                 // async reset, high
    input  wire logic                    i_clock_qualify_n,     // low: edge counts
    input  wire logic                    i_chip_select_first,   // active low
    input  wire logic                    i_chip_select_second,  // active high
    input  wire logic                    i_chip_select_third,   // active low
    input  wire logic                    i_write_n,             // low: write, high: read
    input  wire logic                    i_burst_advance_or_load, // high: advance, low: load
    input  wire logic [ADDR_W-1:0]       i_addr,                // word address
    input  wire logic [LANES-1:0]        i_byte_lane_write_n,   // lane write selects
    input  wire logic [LANES*LANE_W-1:0] i_lane_parity_io,      // data pins, input side
    output logic      [LANES*LANE_W-1:0] o_lane_parity_io,      // data pins, output side
    output logic                         o_lane_parity_io_oe,   // high: drive data pins
    input  wire logic                    i_output_enable_n,     // async output enable
    input  wire logic                    i_burst_order,         // low linear, high interleaved
    input  wire logic                    i_sleep_request,       // high: sleep
    input  wire logic                    i_tck,                 // scan clock pin
    input  wire logic                    i_tms,                 // scan mode select
    input  wire logic                    i_tdi,                 // scan data in
    output logic                         o_tdo,                 // scan data out
    output logic                         o_tdo_oe               // high: drive tdo
);
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH  = 2 ** ADDR_W;

    ////////////////////////////////////////////////////////////////////////////
    // input registers

    logic                en;
    logic                in_cs_r,   in_cs_nxt;
    logic                in_wr_r,   in_wr_nxt;
    logic                in_adv_r,  in_adv_nxt;
    logic [ADDR_W-1:0]   in_addr_r, in_addr_nxt;
    logic                in_zz_r,   in_zz_nxt;

    assign en = ~i_clock_qualify_n;

    always_comb begin
        in_cs_nxt   = ~i_chip_select_first & i_chip_select_second & ~i_chip_select_third;
        in_wr_nxt   = ~i_write_n;
        in_adv_nxt  = i_burst_advance_or_load;
        in_addr_nxt = i_addr;
        in_zz_nxt   = i_sleep_request;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            in_cs_r   <= 1'b0;
            in_wr_r   <= 1'b0;
            in_adv_r  <= 1'b0;
            in_addr_r <= '0;
            in_zz_r   <= 1'b0;
        end else if (en) begin
            in_cs_r   <= in_cs_nxt;
            in_wr_r   <= in_wr_nxt;
            in_adv_r  <= in_adv_nxt;
            in_addr_r <= in_addr_nxt;
            in_zz_r   <= in_zz_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode and burst address

    op_e                 s2_op_r,   s2_op_nxt;
    logic [ADDR_W-1:0]   s2_addr_r, s2_addr_nxt;
    op_e                 last_op_r, last_op_nxt;
    logic [ADDR_W-1:0]   base_r,    base_nxt;
    logic [BURST_W-1:0]  cnt_r,     cnt_nxt;
    logic [BURST_W-1:0]  low;

    always_comb begin
        s2_op_nxt   = OP_IDLE;
        s2_addr_nxt = s2_addr_r;
        last_op_nxt = last_op_r;
        base_nxt    = base_r;
        cnt_nxt     = cnt_r;
        low         = '0;
        if (in_zz_r) begin
            // asleep: no new operation and no burst continues
            last_op_nxt = OP_IDLE;
        end else if (!in_adv_r) begin
            if (in_cs_r) begin
                s2_op_nxt   = in_wr_r ? OP_WRITE : OP_READ;
                s2_addr_nxt = in_addr_r;
                base_nxt    = in_addr_r;
                cnt_nxt     = '0;
            end
            last_op_nxt = s2_op_nxt;
        end else if (last_op_r != OP_IDLE) begin
            // advance keeps the type of the operation that opened the burst
            cnt_nxt     = cnt_r + 1'b1;
            low         = i_burst_order ? (base_r[BURST_W-1:0] ^ cnt_nxt)
                                        : (base_r[BURST_W-1:0] + cnt_nxt);
            s2_op_nxt   = last_op_r;
            s2_addr_nxt = {base_r[ADDR_W-1:BURST_W], low};
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s2_op_r   <= OP_IDLE;
            s2_addr_r <= '0;
            last_op_r <= OP_IDLE;
            base_r    <= '0;
            cnt_r     <= '0;
        end else if (en) begin
            s2_op_r   <= s2_op_nxt;
            s2_addr_r <= s2_addr_nxt;
            last_op_r <= last_op_nxt;
            base_r    <= base_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data phase: read output register and pending write

    logic [DATA_W-1:0]   mem [DEPTH];
    logic [DATA_W-1:0]   rd_word;
    logic [DATA_W-1:0]   dout_r,    dout_nxt;
    logic                drive_r,   drive_nxt;
    logic                wph_r,     wph_nxt;
    logic [ADDR_W-1:0]   waddr_r,   waddr_nxt;
    logic                pend_r,    pend_nxt;
    logic [ADDR_W-1:0]   paddr_r,   paddr_nxt;
    logic [DATA_W-1:0]   pdata_r,   pdata_nxt;
    logic [LANES-1:0]    plane_r,   plane_nxt;
    logic [LANES-1:0]    bus_lane;
    logic                bus_hit;
    logic                hit;

    // newest wins per lane: data on the pins now, then the word waiting to land, then the array
    assign bus_lane = ~i_byte_lane_write_n;
    assign bus_hit  = wph_r && (waddr_r == s2_addr_r);
    assign hit      = pend_r && (paddr_r == s2_addr_r);

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign rd_word[g*LANE_W +: LANE_W] =
                (bus_hit && bus_lane[g]) ? i_lane_parity_io[g*LANE_W +: LANE_W] :
                (hit && plane_r[g])      ? pdata_r[g*LANE_W +: LANE_W]          :
                                           mem[s2_addr_r][g*LANE_W +: LANE_W];
        end
    endgenerate

    always_comb begin
        dout_nxt  = dout_r;
        drive_nxt = 1'b0;
        wph_nxt   = 1'b0;
        waddr_nxt = waddr_r;
        pend_nxt  = wph_r;
        paddr_nxt = paddr_r;
        pdata_nxt = pdata_r;
        plane_nxt = plane_r;
        case (s2_op_r)
            OP_READ: begin
                dout_nxt  = rd_word;
                drive_nxt = 1'b1;
            end
            OP_WRITE: begin
                // drivers off for the cycle the controller owns the bus
                drive_nxt = 1'b0;
                wph_nxt   = 1'b1;
                waddr_nxt = s2_addr_r;
            end
            default: begin
                drive_nxt = 1'b0;
            end
        endcase
        // write data shares the read slot, so a read then a write never collide
        if (wph_r) begin
            paddr_nxt = waddr_r;
            pdata_nxt = i_lane_parity_io;
            plane_nxt = bus_lane;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dout_r  <= '0;
            drive_r <= 1'b0;
            wph_r   <= 1'b0;
            waddr_r <= '0;
            pend_r  <= 1'b0;
            paddr_r <= '0;
            pdata_r <= '0;
            plane_r <= '0;
        end else if (en) begin
            dout_r  <= dout_nxt;
            drive_r <= drive_nxt;
            wph_r   <= wph_nxt;
            waddr_r <= waddr_nxt;
            pend_r  <= pend_nxt;
            paddr_r <= paddr_nxt;
            pdata_r <= pdata_nxt;
            plane_r <= plane_nxt;
        end
    end

    // array is not reset; a pending write lands on the next enabled edge
    always_ff @(posedge i_ref_clk) begin
        if (en && pend_r) begin
            for (int l = 0; l < LANES; l++) begin
                if (plane_r[l]) begin
                    mem[paddr_r][l*LANE_W +: LANE_W] <= pdata_r[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign o_lane_parity_io    = dout_r;
    // sleep and the async enable both override the internal drive timing
    assign o_lane_parity_io_oe = drive_r & ~i_output_enable_n & ~in_zz_r;

    ////////////////////////////////////////////////////////////////////////////
    // scan port

    scan_if scan ();

    assign scan.tck = i_tck;
    assign scan.tms = i_tms;
    assign scan.tdi = i_tdi;
    assign o_tdo    = scan.tdo;
    assign o_tdo_oe = scan.tdo_oe;

    sram_scan_tap #(
        .ID_VALUE (ID_VALUE)
    ) u_tap (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .scan      (scan)
    );
endmodule : sync_burst_sram
`default_nettype wire

//--- sync_burst_sram_properties.sv
// concurrent checks on the burst sram core ports
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_properties
    import sram_pkg::*;
#(
    parameter int LANES  = DEF_LANES,  // data lanes
    parameter int ADDR_W = DEF_ADDR_W  // address bits
) (
    input wire logic                    i_ref_clk,               // clock
    input wire logic                    i_rst,                   // async reset
    input wire logic                    i_clock_qualify_n,       // low: edge counts
    input wire logic                    i_chip_select_first,     // active low
    input wire logic                    i_chip_select_second,    // active high
    input wire logic                    i_chip_select_third,     // active low
    input wire logic                    i_write_n,               // low: write
    input wire logic                    i_burst_advance_or_load, // high: advance
    input wire logic                    i_sleep_request,         // high: sleep
    input wire logic                    i_output_enable_n,       // async enable
    input wire logic [LANES*LANE_W-1:0] o_lane_parity_io,        // read data
    input wire logic                    o_lane_parity_io_oe      // data drive
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire logic sel_w = !i_chip_select_first && i_chip_select_second && !i_chip_select_third;
    wire logic en_w  = !i_clock_qualify_n && !i_sleep_request;
    wire logic ld_w  = !i_clock_qualify_n && !i_burst_advance_or_load;
    sequence rd_s;
        en_w && ld_w && sel_w && i_write_n;
    endsequence
    sequence wr_s;
        en_w && ld_w && sel_w && !i_write_n;
    endsequence
    sequence two_en_s;
        en_w ##1 en_w;
    endsequence
    ////////////////////////////////////////////////////////////
    rd_lat_a: assert property (rd_s ##1 two_en_s |=> i_output_enable_n || o_lane_parity_io_oe)
        else $error("read data not driven two edges after the address");
    wr_tri_a: assert property (wr_s ##1 two_en_s |=> !o_lane_parity_io_oe)
        else $error("data drivers on during write data phase");
    oe_async_a: assert property (i_output_enable_n |-> !o_lane_parity_io_oe)
        else $error("data driven while output enable inactive");
    stall_hold_a: assert property (i_clock_qualify_n [*2] |-> $stable(o_lane_parity_io))
        else $error("read data moved while clock qualify was high");
    data_edge_a: assert property ($changed(o_lane_parity_io) |-> $past(!i_clock_qualify_n))
        else $error("read data changed on an ignored edge");
    desel_idle_a: assert property (ld_w && !sel_w ##1 two_en_s |=> !o_lane_parity_io_oe)
        else $error("deselected load produced a data phase");
    adv_idle_a: assert property (ld_w && !sel_w ##1 en_w && i_burst_advance_or_load ##1 two_en_s
        |=> !o_lane_parity_io_oe)
        else $error("advance after deselect produced a data phase");
    sleep_off_a: assert property (!i_clock_qualify_n && i_sleep_request |=> !o_lane_parity_io_oe)
        else $error("data driven while asleep");
endmodule : sync_burst_sram_properties
bind sync_burst_sram sync_burst_sram_properties #(.LANES(LANES), .ADDR_W(ADDR_W)) props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clock_qualify_n(i_clock_qualify_n),
    .i_chip_select_first(i_chip_select_first), .i_chip_select_second(i_chip_select_second),
    .i_chip_select_third(i_chip_select_third), .i_write_n(i_write_n),
    .i_burst_advance_or_load(i_burst_advance_or_load), .i_sleep_request(i_sleep_request),
    .i_output_enable_n(i_output_enable_n), .o_lane_parity_io(o_lane_parity_io),
    .o_lane_parity_io_oe(o_lane_parity_io_oe));
`default_nettype wire

//--- sram_controller_model.sv
// controller side model: write data phase and the shared data wire
`timescale 1ns/10ps
`default_nettype none
module sram_controller_model
    import sram_pkg::*;
#(
    parameter int DW = DEF_LANES*LANE_W, // bus width
    parameter int LN = DEF_LANES         // lanes
) (
    input  wire logic          i_ref_clk,  // clock
    input  wire logic          i_rst,      // reset
    input  wire logic          i_qual_n,   // clock qualify
    input  wire logic          i_sel,      // selects active, no sleep
    input  wire logic          i_write_n,  // command is a read
    input  wire logic          i_adv,      // advance burst
    input  wire logic [DW-1:0] i_wdata,    // data for this command
    input  wire logic [LN-1:0] i_wlanes_n, // lane selects for this command
    input  wire logic [DW-1:0] i_dev_data, // device output
    input  wire logic          i_dev_oe,   // device drives
    output logic      [DW-1:0] o_bus,      // resolved wire
    output logic      [LN-1:0] o_lanes_n   // lane selects
);
    logic          open_r, wopen_r, v1_r, v2_r, v3_r;
    logic [DW-1:0] d1_r, d2_r, d3_r, last_r;
    logic [LN-1:0] l1_r, l2_r, l3_r;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {open_r, wopen_r, v1_r, v2_r, v3_r} <= 5'h00;
        end else if (!i_qual_n) begin
            if (!i_adv) begin
                open_r  <= i_sel;
                wopen_r <= !i_write_n;
            end
            v1_r <= i_adv ? (open_r && wopen_r) : (i_sel && !i_write_n);
            d1_r <= i_wdata;
            l1_r <= i_wlanes_n;
            v2_r <= v1_r;
            d2_r <= d1_r;
            l2_r <= l1_r;
            // write data goes out in the bus cycle a read would use
            v3_r <= v2_r;
            d3_r <= d2_r;
            l3_r <= l2_r;
        end
    end
    always_ff @(posedge i_ref_clk) last_r <= o_bus;
    // an idle wire flips each cycle so stale data can never match
    assign o_bus     = i_dev_oe ? i_dev_data : (v3_r ? d3_r : ~last_r);
    assign o_lanes_n = v3_r ? l3_r : ~l3_r;
endmodule : sram_controller_model
`default_nettype wire

//--- sync_burst_sram_test.sv
// self-checking bench for the burst sram core
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_test;
    import sram_pkg::*;
    localparam int DW = DEF_LANES*LANE_W;
    logic clk = 1'b0, rst = 1'b1, qn = 1'b1, cs1 = 1'b1, cs2 = 1'b0, cs3 = 1'b1, wr_n = 1'b1;
    logic adv = 1'b0, oe_n = 1'b0, order = 1'b0, sleep = 1'b0, open_sel = 1'b0, open_w = 1'b0;
    logic [DEF_ADDR_W-1:0] addr = '0;
    logic [DW-1:0]         wdata = '0, bus, dout;
    logic [DEF_LANES-1:0]  wlanes = '1, lanes_n;
    logic                  dout_oe;
    logic                  tck = 1'b0, tms = 1'b1, tdo, tdo_oe;
    logic [DW:0]           pipe [3] = '{default: '0};
    logic [DW-1:0]         mem [int];
    int                    num_errors = 0, compares = 0, cycles = 0;
    always #5 clk = ~clk;
    sync_burst_sram dut (.i_ref_clk(clk), .i_rst(rst), .i_clock_qualify_n(qn), .i_chip_select_first(cs1),
        .i_chip_select_second(cs2), .i_chip_select_third(cs3), .i_write_n(wr_n),
        .i_burst_advance_or_load(adv), .i_addr(addr), .i_byte_lane_write_n(lanes_n),
        .i_lane_parity_io(bus), .o_lane_parity_io(dout), .o_lane_parity_io_oe(dout_oe),
        .i_output_enable_n(oe_n), .i_burst_order(order), .i_sleep_request(sleep), .i_tck(tck),
        .i_tms(tms), .i_tdi(1'b0), .o_tdo(tdo), .o_tdo_oe(tdo_oe));
    sram_controller_model ctl (.i_ref_clk(clk), .i_rst(rst), .i_qual_n(qn),
        .i_sel(!cs1 && cs2 && !cs3 && !sleep), .i_write_n(wr_n), .i_adv(adv), .i_wdata(wdata),
        .i_wlanes_n(wlanes), .i_dev_data(dout), .i_dev_oe(dout_oe), .o_bus(bus), .o_lanes_n(lanes_n));
    ////////////////////////////////////////////////////////////
    task give_verdict;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one enabled edge; checks the op issued three calls earlier
    task cmd(input logic [2:0] cs, input logic w, input logic a, input logic [DEF_ADDR_W-1:0] ad,
             input logic [DW-1:0] d, input logic [DEF_LANES-1:0] ln);
        logic rd;
        @(negedge clk);
        chk(DW'(dout_oe), DW'(pipe[2][DW]));
        if (pipe[2][DW]) chk(dout, pipe[2][DW-1:0]);
        if (!a) begin
            open_sel = &cs && !sleep;
            open_w   = w;
        end
        rd = open_sel && !open_w;
        if (open_sel && open_w) for (int k = 0; k < DEF_LANES; k++) if (!ln[k]) mem[ad][k*9+:9] = d[k*9+:9];
        pipe[2] = pipe[1];
        pipe[1] = pipe[0];
        pipe[0] = {rd, rd ? mem[ad] : DW'(0)};
        {qn, cs1, cs2, cs3, wr_n, adv, addr, wdata, wlanes} = {1'b0, !cs[0], cs[1], !cs[2], !w, a, ad, d, ln};
    endtask : cmd
    task idle(input int n);
        repeat (n) cmd(3'h0, 1'b0, 1'b0, '0, '0, '1);
    endtask : idle
    ////////////////////////////////////////////////////////////
    task test_b2b;
        cmd(3'h7, 1'b1, 1'b0, 18'h00010, 36'h1_2345_6789, 4'h0);
        cmd(3'h7, 1'b0, 1'b0, 18'h00010, '0, '1);
        cmd(3'h7, 1'b1, 1'b0, 18'h00010, 36'hF_FFFF_FFFF, 4'hA);
        cmd(3'h7, 1'b0, 1'b0, 18'h00010, '0, '1);
        for (int i = 4; i < 8; i++) cmd(3'h7, 1'b1, 1'b0, DEF_ADDR_W'(i), {4{9'(i * 37)}}, 4'h0);
        cmd(3'h7, 1'b0, 1'b0, 18'h00004, '0, '1);
        idle(3);
    endtask : test_b2b
    task test_burst;
        for (int o = 0; o < 2; o++) begin
            order = o[0];
            cmd(3'h7, 1'b0, 1'b0, 18'h00006, '0, '1);
            for (int n = 1; n < 6; n++)
                cmd(3'h7, 1'b0, 1'b1, {16'h0001, o[0] ? 2'h2 ^ 2'(n) : 2'(2 + n)}, '0, '1);
            idle(3);
        end
    endtask : test_burst
    task test_select;
        for (int i = 0; i < 3; i++) begin
            cmd(~(3'h1 << i), 1'b0, 1'b0, 18'h00005, '0, '1);
            cmd(3'h7, 1'b0, 1'b1, 18'h00006, '0, '1);
        end
        idle(3);
    endtask : test_select
    task test_stall_oe;
        cmd(3'h7, 1'b0, 1'b0, 18'h00005, '0, '1);
        idle(2);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            qn = 1'b1;
            chk(dout, mem[5]);
            oe_n = i[0];
            #1 chk(DW'(dout_oe), DW'(!i[0]));
        end
        oe_n = 1'b0;
        idle(3);
    endtask : test_stall_oe
    task test_sleep;
        sleep = 1'b1;
        cmd(3'h7, 1'b0, 1'b0, 18'h00007, '0, '1);
        cmd(3'h7, 1'b1, 1'b0, 18'h00007, '0, '0);
        idle(3);
        sleep = 1'b0;
        cmd(3'h7, 1'b0, 1'b0, 18'h00007, '0, '1);
        idle(3);
    endtask : test_sleep
    // scan clock runs slow against the system clock: two cycles per phase
    task tck_cycle(input logic m);
        @(negedge clk);
        {tms, tck} = {m, 1'b1};
        repeat (2) @(negedge clk);
        tck = 1'b0;
        repeat (2) @(negedge clk);
    endtask : tck_cycle
    task test_scan;
        logic [IDCODE_W-1:0] id;
        tck_cycle(1'b0);
        tck_cycle(1'b1);
        tck_cycle(1'b0);
        // first pulse enters shift with the id loaded, each later one moves it a bit
        for (int b = 0; b < IDCODE_W; b++) begin
            tck_cycle(1'b0);
            chk(DW'(tdo_oe), DW'(1));
            id[b] = tdo;
        end
        chk(DW'(id), DW'(IDCODE_DEF));
        repeat (5) tck_cycle(1'b1);
        chk(DW'(tdo_oe), DW'(0));
    endtask : test_scan
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        test_b2b();
        test_burst();
        test_select();
        test_stall_oe();
        test_sleep();
        test_scan();
        give_verdict();
    end
endmodule : sync_burst_sram_test
`default_nettype wire
